/* File: sim/tb_top.sv */
// Self-checking testbench for the power and clock key control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import pckc_pkg::*;
    localparam int SHORT_SLOW = 200;
    localparam int LONG_SLOW  = 2700;
    logic        clock;
    logic        reset;
    logic        clock_enable;
    logic [31:0] address;
    logic [15:0] write_data;
    logic        write_strobe;
    logic        read_strobe;
    logic [15:0] read_data;
    logic        wake_event;
    logic        pwm_en;
    logic        uart_en;
    logic        serial_en;
    logic        ext_sel;
    logic        xtal_pll;
    logic [2:0]  divider;
    logic [3:0]  enables;
    logic        awake;
    int          n_fail;
    int          comparisons;
    // Key-before, data and key-after addresses: 0 core, 1 clock source, 2 peripheral gating
    logic [31:0] kb_addr [3] = '{ADDR_CORE_KEY_BEF, ADDR_CLK_KEY_BEF, ADDR_PER_KEY_BEF};
    logic [31:0] rg_addr [3] = '{ADDR_CORE_CTRL, ADDR_CLK_SEL, ADDR_PER_GATE};
    logic [31:0] ka_addr [3] = '{ADDR_CORE_KEY_AFT, ADDR_CLK_KEY_AFT, ADDR_PER_KEY_AFT};

    pckc_top #(.WAKE_SHORT_SLOW(SHORT_SLOW), .WAKE_LONG_SLOW(LONG_SLOW)) dut (
        .clock(clock), .reset(reset), .clock_enable(clock_enable), .address(address),
        .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe),
        .read_data(read_data), .wake_event(wake_event), .pwm_clock_enable(pwm_en),
        .uart_clock_enable(uart_en), .serial_pair_clock_enable(serial_en),
        .external_clock_select(ext_sel), .crystal_to_pll(xtal_pll), .core_clock_divider(divider),
        .core_enable(enables[0]), .peripheral_enable(enables[1]), .pll_enable(enables[2]),
        .crystal_enable(enables[3]), .core_awake(awake));

    // 40 MHz system clock
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic results;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One write strobe; a gap cycle follows so strobes never merge
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge clock);
        address <= a; write_data <= d; write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [31:0] a, input logic [15:0] exp);
        @(posedge clock);
        address <= a; read_strobe <= 1'b1;
        @(posedge clock);
        read_strobe <= 1'b0;
        #1 check(read_data, exp);
    endtask

    task automatic keyed(input int k, input logic [15:0] d, input logic [15:0] kb, input logic [15:0] ka);
        wr(kb_addr[k], kb);
        wr(rg_addr[k], d);
        wr(ka_addr[k], ka);
    endtask

    // Outputs follow the register one cycle after it commits
    task automatic settle;
        repeat (2) @(posedge clock);
        #1;
    endtask

    task automatic t_reset;
        rd(ADDR_PER_GATE, 16'h0124);
        rd(ADDR_CORE_CTRL, 16'h007b);
        rd(ADDR_CLK_SEL, 16'h0000);
        rd(ADDR_CORE_KEY_BEF, 16'h0000);
        rd(32'hffff0500, 16'h0000);
        check(16'({pwm_en, uart_en, serial_en}), 16'h0007);
        check(16'({divider, enables, awake, ext_sel, xtal_pll}), 16'h01fc);
    endtask

    task automatic t_gating;
        logic [15:0] vals [5] = '{16'h0004, 16'h0120, 16'h0100, 16'h0020, 16'h0124};
        foreach (vals[i]) begin
            keyed(2, vals[i], KEY_PER_BEF, KEY_PER_AFT);
            settle();
            rd(ADDR_PER_GATE, vals[i] & 16'h0124);
            check(16'({pwm_en, uart_en, serial_en}), 16'({vals[i][8], vals[i][5], vals[i][2]}));
        end
    endtask

    // Broken key sequences must leave the gating register at 0x124
    task automatic t_refuse;
        wr(ADDR_PER_GATE, 16'h0000);
        keyed(2, 16'h0000, 16'h0077, KEY_PER_AFT);
        keyed(2, 16'h0000, KEY_PER_BEF, 16'h00b0);
        wr(ADDR_PER_KEY_BEF, KEY_PER_BEF);
        wr(ADDR_PER_GATE, 16'h0000);
        wr(32'hffff0500, 16'h0000);
        wr(ADDR_PER_KEY_AFT, KEY_PER_AFT);
        keyed(0, 16'h0000, KEY_PER_BEF, KEY_PER_AFT);
        clock_enable <= 1'b0;
        keyed(2, 16'h0000, KEY_PER_BEF, KEY_PER_AFT);
        clock_enable <= 1'b1;
        settle();
        rd(ADDR_PER_GATE, 16'h0124);
        rd(ADDR_CORE_CTRL, 16'h007b);
        check(16'({pwm_en, uart_en, serial_en}), 16'h0007);
        // A read between the keyed writes does not break the sequence
        wr(ADDR_PER_KEY_BEF, KEY_PER_BEF);
        rd(ADDR_PER_GATE, 16'h0124);
        wr(ADDR_PER_GATE, 16'h0020);
        wr(ADDR_PER_KEY_AFT, KEY_PER_AFT);
        rd(ADDR_PER_GATE, 16'h0020);
    endtask

    task automatic t_clksel;
        logic [15:0] v;
        for (int i = 0; i < 8; i++) begin
            v = 16'(i);
            keyed(1, v, KEY_CLK_BEF, KEY_CLK_AFT);
            settle();
            rd(ADDR_CLK_SEL, v);
            check(16'(ext_sel), 16'(v[2]));
            check(16'(xtal_pll), 16'(v[1:0] == 2'b10));
        end
        keyed(1, 16'h0002, KEY_CLK_BEF, KEY_CLK_AFT);
        rd(ADDR_CLK_SEL, 16'h0002);
    endtask

    task automatic t_divider;
        for (int cd = 0; cd < 8; cd++) begin
            keyed(0, 16'h0078 | 16'(cd), KEY_CORE_BEF, KEY_CORE_AFT);
            settle();
            check(16'(divider), 16'(cd));
            rd(ADDR_CORE_CTRL, 16'h0078 | 16'(cd));
        end
    endtask

    // Enter a low-power mode, wake it and time the return to run
    task automatic t_wake(input logic [3:0] mode, input int cd, input int target);
        int n;
        keyed(0, 16'({mode, 3'(cd)}), KEY_CORE_BEF, KEY_CORE_AFT);
        settle();
        check(16'(enables), 16'(mode));
        check(16'(awake), 16'h0000);
        rd(ADDR_WAKE_STATUS, 16'h0001);
        @(posedge clock);
        wake_event <= 1'b1;
        @(posedge clock);
        wake_event <= 1'b0;
        n = 0;
        #1;
        while (awake !== 1'b1 && n < 4000) begin
            @(posedge clock);
            #1 n++;
        end
        check(16'(n >= target && n <= target + 3), 16'h0001);
        rd(ADDR_CORE_CTRL, 16'h0078 | 16'(cd));
        check(16'(enables), 16'h000f);
        rd(ADDR_WAKE_STATUS, 16'h0000);
    endtask

    // Watchdog sized well beyond the longest wake sequences
    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        results();
    end

    initial begin
        n_fail = 0;
        comparisons = 0;
        reset = 1'b1;
        clock_enable = 1'b1;
        address = 32'h00000000;
        write_data = 16'h0000;
        write_strobe = 1'b0;
        read_strobe = 1'b0;
        wake_event = 1'b0;
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        t_reset();
        t_gating();
        t_refuse();
        t_clksel();
        t_divider();
        t_wake(MODE_PAUSE, 0, WAKE_SHORT_CYC);
        t_wake(MODE_NAP, 7, WAKE_SHORT_CYC + (SHORT_SLOW - WAKE_SHORT_CYC) / 7 * 7);
        t_wake(MODE_SLEEP, 0, WAKE_LONG_CYC);
        t_wake(MODE_STOP, 7, WAKE_LONG_CYC + (LONG_SLOW - WAKE_LONG_CYC) / 7 * 7);
        results();
    end
endmodule // tb_top
`default_nettype wire

/* File: verilog/pckc_pkg.sv */
// Package for the power and clock key control block: map, fields, keys, timing
package pckc_pkg;
    localparam int          PCKC_AW            = 32;
    localparam int          PCKC_DW            = 16;
    localparam logic [31:0] ADDR_CORE_KEY_BEF  = 32'hffff0404;
    localparam logic [31:0] ADDR_CORE_CTRL     = 32'hffff0408;
    localparam logic [31:0] ADDR_CORE_KEY_AFT  = 32'hffff040c;
    localparam logic [31:0] ADDR_CLK_KEY_BEF   = 32'hffff0410;
    localparam logic [31:0] ADDR_CLK_SEL       = 32'hffff0414;
    localparam logic [31:0] ADDR_CLK_KEY_AFT   = 32'hffff0418;
    localparam logic [31:0] ADDR_PER_KEY_BEF   = 32'hffff0434;
    localparam logic [31:0] ADDR_PER_GATE      = 32'hffff0438;
    localparam logic [31:0] ADDR_PER_KEY_AFT   = 32'hffff043c;
    localparam logic [31:0] ADDR_WAKE_STATUS   = 32'hffff0440;
    // Key values
    localparam logic [15:0] KEY_CORE_BEF       = 16'h0001;
    localparam logic [15:0] KEY_CORE_AFT       = 16'h00f4;
    localparam logic [15:0] KEY_PER_BEF        = 16'h0076;
    localparam logic [15:0] KEY_PER_AFT        = 16'h00b1;
    localparam logic [15:0] KEY_CLK_BEF        = 16'h00aa;
    localparam logic [15:0] KEY_CLK_AFT        = 16'h0055;
    // Reset values and write masks
    localparam logic [15:0] CORE_CTRL_RST      = 16'h007b;
    localparam logic [15:0] CORE_CTRL_MASK     = 16'h007f;
    localparam logic [15:0] PER_GATE_RST       = 16'h0124;
    localparam logic [15:0] PER_GATE_MASK      = 16'h0124;
    localparam logic [15:0] CLK_SEL_RST        = 16'h0000;
    localparam logic [15:0] CLK_SEL_MASK       = 16'h0007;
    // Field positions
    localparam int          BIT_PWM            = 8;
    localparam int          BIT_UART           = 5;
    localparam int          BIT_SERIAL         = 2;
    localparam int          BIT_EXT_CLK        = 2;
    localparam int          OSCILLATOR_SELECT_LO            = 0;
    localparam int          CD_LO              = 0;
    localparam int          MODE_LO            = 3;
    localparam int          BIT_CORE_EN        = 3;
    localparam int          BIT_PER_EN         = 4;
    localparam int          BIT_PLL_EN         = 5;
    localparam int          BIT_XTAL_EN        = 6;
    localparam logic [1:0]  OSCILLATOR_SELECT_CRYSTAL       = 2'h2;
    localparam logic [3:0]  MODE_ACTIVE        = 4'hf;
    localparam logic [3:0]  MODE_PAUSE         = 4'he;
    localparam logic [3:0]  MODE_NAP           = 4'hc;
    localparam logic [3:0]  MODE_SLEEP         = 4'h8;
    localparam logic [3:0]  MODE_STOP          = 4'h0;
    // Wake times in ns at the fastest core divider, per 40 MHz clock
    localparam int          CLK_PERIOD_NS      = 25;
    localparam int          WAKE_SHORT_NS      = 4800;
    localparam int          WAKE_LONG_NS       = 66000;
    localparam int          WAKE_SHORT_CYC     = (WAKE_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          WAKE_LONG_CYC      = (WAKE_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Slowest-divider wake times, 660 us and 900 us
    localparam int          WAKE_SHORT_SLOW_US = 660;
    localparam int          WAKE_LONG_SLOW_US  = 900;
    localparam int          WAKE_SHORT_SLOW_CYC = WAKE_SHORT_SLOW_US * 1000 / CLK_PERIOD_NS;
    localparam int          WAKE_LONG_SLOW_CYC  = WAKE_LONG_SLOW_US * 1000 / CLK_PERIOD_NS;
    localparam int          WAKE_CW            = 16;
    localparam int          CD_STEPS           = 7;  // Divider steps from the fastest code to the slowest
    typedef enum logic [1:0] {PCKC_IDLE, PCKC_ARMED, PCKC_WRITTEN} pckc_key_t;
    typedef enum logic [1:0] {PCKC_RUN, PCKC_LOW, PCKC_WAKE} pckc_pwr_t;
endpackage

/* File: verilog/pckc_top.sv */
// Power and clock key control block: keyed registers, clock gates, power modes
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module pckc_top #(
    parameter int WAKE_SHORT_SLOW = pckc_pkg::WAKE_SHORT_SLOW_CYC,
    parameter int WAKE_LONG_SLOW  = pckc_pkg::WAKE_LONG_SLOW_CYC
) (
    input  wire logic                         clock,
    input  wire logic                         reset,
    input  wire logic                         clock_enable,
    input  wire logic [pckc_pkg::PCKC_AW-1:0] address,
    input  wire logic [pckc_pkg::PCKC_DW-1:0] write_data,
    input  wire logic                         write_strobe,
    input  wire logic                         read_strobe,
    output var  logic [pckc_pkg::PCKC_DW-1:0] read_data,
    input  wire logic                         wake_event,
    output var  logic                         pwm_clock_enable,
    output var  logic                         uart_clock_enable,
    output var  logic                         serial_pair_clock_enable,
    output var  logic                         external_clock_select,
    output var  logic                         crystal_to_pll,
    output var  logic [2:0]                   core_clock_divider,
    output var  logic                         core_enable,
    output var  logic                         peripheral_enable,
    output var  logic                         pll_enable,
    output var  logic                         crystal_enable,
    output var  logic                         core_awake
);
    import pckc_pkg::*;

    logic [15:0] core_power_control;
    logic [15:0] peripheral_clock_gating;
    logic [15:0] clock_source_select;
    pckc_key_t   core_seq;
    pckc_key_t   per_seq;
    pckc_key_t   clk_seq;
    logic [15:0] core_pending;
    logic [15:0] per_pending;
    logic [15:0] clk_pending;
    pckc_pwr_t   pwr_state;
    logic [WAKE_CW-1:0] wake_count;
    logic [WAKE_CW-1:0] wake_target;

    // Bus decode: a write hits at most one address; unmapped writes hit none
    wire wr_core_bef = write_strobe && address == ADDR_CORE_KEY_BEF;
    wire wr_core     = write_strobe && address == ADDR_CORE_CTRL;
    wire wr_core_aft = write_strobe && address == ADDR_CORE_KEY_AFT;
    wire wr_per_bef  = write_strobe && address == ADDR_PER_KEY_BEF;
    wire wr_per      = write_strobe && address == ADDR_PER_GATE;
    wire wr_per_aft  = write_strobe && address == ADDR_PER_KEY_AFT;
    wire wr_clk_bef  = write_strobe && address == ADDR_CLK_KEY_BEF;
    wire wr_clk      = write_strobe && address == ADDR_CLK_SEL;
    wire wr_clk_aft  = write_strobe && address == ADDR_CLK_KEY_AFT;

    // Commit only when the key-after write follows the armed data write
    wire commit_core = wr_core_aft && core_seq == PCKC_WRITTEN && write_data == KEY_CORE_AFT;
    wire commit_per  = wr_per_aft && per_seq == PCKC_WRITTEN && write_data == KEY_PER_AFT;
    wire commit_clk  = wr_clk_aft && clk_seq == PCKC_WRITTEN && write_data == KEY_CLK_AFT;

    // Key sequencer: any other write in between breaks the sequence
    function automatic pckc_key_t next_seq(input pckc_key_t cur, input logic bef,
                                           input logic [15:0] d, input logic [15:0] key,
                                           input logic data_wr);
        pckc_key_t r;
        r = PCKC_IDLE;
        if (bef && d == key) begin
            r = PCKC_ARMED;
        end else if (data_wr && cur == PCKC_ARMED) begin
            r = PCKC_WRITTEN;
        end
        return r;
    endfunction

    // Sequences only move on a write; reads leave them untouched
    wire [1:0] next_core_seq = write_strobe ? next_seq(core_seq, wr_core_bef, write_data, KEY_CORE_BEF, wr_core)
                                            : core_seq;
    wire [1:0] next_per_seq  = write_strobe ? next_seq(per_seq, wr_per_bef, write_data, KEY_PER_BEF, wr_per)
                                            : per_seq;
    wire [1:0] next_clk_seq  = write_strobe ? next_seq(clk_seq, wr_clk_bef, write_data, KEY_CLK_BEF, wr_clk)
                                            : clk_seq;

    // Mode decode and wake time; the wake time scales with the divider
    wire [3:0] mode       = core_power_control[MODE_LO+3:MODE_LO];
    wire       mode_low   = mode != MODE_ACTIVE;
    wire       deep_mode  = mode == MODE_SLEEP || mode == MODE_STOP;
    wire [2:0] cd         = core_power_control[CD_LO+2:CD_LO];
    wire [WAKE_CW-1:0] short_fast = WAKE_CW'(WAKE_SHORT_CYC);
    wire [WAKE_CW-1:0] long_fast  = WAKE_CW'(WAKE_LONG_CYC);
    wire [WAKE_CW-1:0] short_step = WAKE_CW'((WAKE_SHORT_SLOW - WAKE_SHORT_CYC) / CD_STEPS);
    wire [WAKE_CW-1:0] long_step  = WAKE_CW'((WAKE_LONG_SLOW - WAKE_LONG_CYC) / CD_STEPS);
    wire [WAKE_CW-1:0] next_wake_target = deep_mode ? WAKE_CW'(long_fast + long_step * cd)
                                                    : WAKE_CW'(short_fast + short_step * cd);
    wire wake_done = pwr_state == PCKC_WAKE && wake_count >= wake_target;

    // Read mux; key registers and unmapped addresses read as zero
    wire [15:0] next_read_data =
        !read_strobe                  ? 16'h0000 :
        address == ADDR_CORE_CTRL     ? core_power_control :
        address == ADDR_PER_GATE      ? peripheral_clock_gating :
        address == ADDR_CLK_SEL       ? clock_source_select :
        address == ADDR_WAKE_STATUS   ? {14'h0000, pwr_state} : 16'h0000;

    // Keyed registers, wake restore and sequencers
    always_ff @(posedge clock) begin
        if (reset) begin
            core_power_control      <= CORE_CTRL_RST;
            peripheral_clock_gating <= PER_GATE_RST;
            clock_source_select     <= CLK_SEL_RST;
            core_seq                <= PCKC_IDLE;
            per_seq                 <= PCKC_IDLE;
            clk_seq                 <= PCKC_IDLE;
            core_pending            <= 16'h0000;
            per_pending             <= 16'h0000;
            clk_pending             <= 16'h0000;
            read_data               <= 16'h0000;
        end else if (clock_enable) begin
            core_seq  <= pckc_key_t'(next_core_seq);
            per_seq   <= pckc_key_t'(next_per_seq);
            clk_seq   <= pckc_key_t'(next_clk_seq);
            read_data <= next_read_data;
            if (wr_core) core_pending <= write_data & CORE_CTRL_MASK;
            if (wr_per)  per_pending  <= write_data & PER_GATE_MASK;   // Reserved bits dropped
            if (wr_clk)  clk_pending  <= write_data & CLK_SEL_MASK;
            if (wake_event && mode_low) begin
                core_power_control[BIT_PLL_EN]  <= 1'b1;
                core_power_control[BIT_PER_EN]  <= 1'b1;
                core_power_control[BIT_CORE_EN] <= 1'b1;
                core_power_control[BIT_XTAL_EN] <= 1'b1;
            end else if (commit_core) begin
                core_power_control <= core_pending;
            end
            if (commit_per)  peripheral_clock_gating <= per_pending;
            if (commit_clk)  clock_source_select     <= clk_pending;
        end
    end

    // Power state: wait out the wake time before the core runs again
    always_ff @(posedge clock) begin
        if (reset) begin
            pwr_state   <= PCKC_RUN;
            wake_count  <= '0;
            wake_target <= '0;
        end else if (clock_enable) begin
            unique case (pwr_state)
                PCKC_RUN: if (mode_low) pwr_state <= PCKC_LOW;
                PCKC_LOW: begin
                    wake_target <= next_wake_target;
                    wake_count  <= '0;
                    if (wake_event) pwr_state <= PCKC_WAKE;
                end
                PCKC_WAKE: begin
                    wake_count <= wake_count + 1'b1;
                    if (wake_done) pwr_state <= PCKC_RUN;
                end
            endcase
        end
    end

    // Clock gates and selects, registered so outputs come from flops
    always_ff @(posedge clock) begin
        if (reset) begin
            pwm_clock_enable         <= 1'b1;
            uart_clock_enable        <= 1'b1;
            serial_pair_clock_enable <= 1'b1;
            external_clock_select    <= 1'b0;
            crystal_to_pll           <= 1'b0;
            core_clock_divider       <= CORE_CTRL_RST[CD_LO+2:CD_LO];
            core_enable              <= 1'b1;
            peripheral_enable        <= 1'b1;
            pll_enable               <= 1'b1;
            crystal_enable           <= 1'b1;
            core_awake               <= 1'b1;
        end else if (clock_enable) begin
            pwm_clock_enable         <= peripheral_clock_gating[BIT_PWM];
            uart_clock_enable        <= peripheral_clock_gating[BIT_UART];
            serial_pair_clock_enable <= peripheral_clock_gating[BIT_SERIAL];
            external_clock_select    <= clock_source_select[BIT_EXT_CLK];
            crystal_to_pll           <= clock_source_select[OSCILLATOR_SELECT_LO+1:OSCILLATOR_SELECT_LO] == OSCILLATOR_SELECT_CRYSTAL;
            core_clock_divider       <= cd;
            core_enable              <= core_power_control[BIT_CORE_EN];
            peripheral_enable        <= core_power_control[BIT_PER_EN];
            pll_enable               <= core_power_control[BIT_PLL_EN];
            crystal_enable           <= core_power_control[BIT_XTAL_EN];
            core_awake               <= pwr_state == PCKC_RUN && !mode_low;
        end
    end

    // Checks
    chk_gate_needs_key: assert property (@(posedge clock) disable iff (reset)
        $changed(peripheral_clock_gating) |-> $past(per_seq) == PCKC_WRITTEN)
        else $error("gating register changed without key sequence");
    chk_core_needs_key: assert property (@(posedge clock) disable iff (reset)
        ($changed(core_power_control) && !$past(wake_event)) |-> $past(core_seq) == PCKC_WRITTEN)
        else $error("core control changed without key sequence");
    chk_pwm_follows_bit: assert property (@(posedge clock) disable iff (reset)
        clock_enable |=> pwm_clock_enable == $past(peripheral_clock_gating[BIT_PWM]))
        else $error("pwm clock gate wrong");
    chk_uart_follows_bit: assert property (@(posedge clock) disable iff (reset)
        clock_enable |=> uart_clock_enable == $past(peripheral_clock_gating[BIT_UART]))
        else $error("uart clock gate wrong");
    chk_serial_follows_bit: assert property (@(posedge clock) disable iff (reset)
        clock_enable |=> serial_pair_clock_enable == $past(peripheral_clock_gating[BIT_SERIAL]))
        else $error("serial clock gate wrong");
    chk_reset_gating: assert property (@(posedge clock)
        $fell(reset) |-> peripheral_clock_gating == PER_GATE_RST && core_clock_divider == CORE_CTRL_RST[CD_LO+2:CD_LO])
        else $error("reset values wrong");
    chk_wake_restores: assert property (@(posedge clock) disable iff (reset)
        (wake_event && mode_low && clock_enable) |=> core_power_control[BIT_CORE_EN] && core_power_control[BIT_PLL_EN])
        else $error("wake did not restore enables");
    chk_crystal_code: assert property (@(posedge clock) disable iff (reset)
        clock_enable |=> crystal_to_pll == ($past(clock_source_select[1:0]) == OSCILLATOR_SELECT_CRYSTAL))
        else $error("oscillator select wrong");
    // Keyed registers move only on their own completed sequence; core control also moves on a wake
    chk_clk_needs_key: assert property (@(posedge clock) disable iff (reset)
        $changed(clock_source_select) |-> $past(clk_seq) == PCKC_WRITTEN)
        else $error("clock select changed without key sequence");
    chk_gate_commit_value: assert property (@(posedge clock) disable iff (reset)
        (commit_per && clock_enable) |=> peripheral_clock_gating == $past(per_pending))
        else $error("gating register took wrong value");
    chk_clk_commit_value: assert property (@(posedge clock) disable iff (reset)
        (commit_clk && clock_enable) |=> clock_source_select == $past(clk_pending))
        else $error("clock select took wrong value");
    chk_core_commit_value: assert property (@(posedge clock) disable iff (reset)
        (commit_core && clock_enable && !(wake_event && mode_low)) |=> core_power_control == $past(core_pending))
        else $error("core control took wrong value");
    // Outputs track their register bits one cycle later
    chk_ext_follows_bit: assert property (@(posedge clock) disable iff (reset)
        clock_enable |=> external_clock_select == $past(clock_source_select[BIT_EXT_CLK]))
        else $error("external clock select wrong");
    chk_divider_follows_field: assert property (@(posedge clock) disable iff (reset)
        clock_enable |=> core_clock_divider == $past(core_power_control[CD_LO+2:CD_LO]))
        else $error("core clock divider wrong");
    chk_core_enable_bit: assert property (@(posedge clock) disable iff (reset)
        clock_enable |=> core_enable == $past(core_power_control[BIT_CORE_EN]))
        else $error("core enable wrong");
    chk_per_enable_bit: assert property (@(posedge clock) disable iff (reset)
        clock_enable |=> peripheral_enable == $past(core_power_control[BIT_PER_EN]))
        else $error("peripheral enable wrong");
    chk_pll_enable_bit: assert property (@(posedge clock) disable iff (reset)
        clock_enable |=> pll_enable == $past(core_power_control[BIT_PLL_EN]))
        else $error("pll enable wrong");
    chk_awake_when_active: assert property (@(posedge clock) disable iff (reset)
        clock_enable |=> core_awake == ($past(pwr_state) == PCKC_RUN && $past(mode) == MODE_ACTIVE))
        else $error("core awake flag wrong");
    // A low clock enable freezes registers and outputs alike
    chk_freeze_gating: assert property (@(posedge clock) disable iff (reset)
        !clock_enable |=> $stable(peripheral_clock_gating) && $stable(pwm_clock_enable))
        else $error("gating moved while frozen");
    chk_freeze_power: assert property (@(posedge clock) disable iff (reset)
        !clock_enable |=> $stable(core_power_control) && $stable(pwr_state))
        else $error("power state moved while frozen");
    // Wake timing: hold in wake until the target count, then run
    chk_wake_waits: assert property (@(posedge clock) disable iff (reset)
        (clock_enable && pwr_state == PCKC_WAKE && wake_count < wake_target) |=> pwr_state == PCKC_WAKE)
        else $error("wake ended early");
    chk_wake_ends: assert property (@(posedge clock) disable iff (reset)
        (clock_enable && wake_done) |=> pwr_state == PCKC_RUN)
        else $error("wake did not end");
    chk_deep_wake_long: assert property (@(posedge clock) disable iff (reset)
        ($rose(pwr_state == PCKC_WAKE) && $past(deep_mode)) |-> wake_target >= long_fast)
        else $error("deep wake time too short");
    chk_wake_restores_per: assert property (@(posedge clock) disable iff (reset)
        (wake_event && mode_low && clock_enable) |=> core_power_control[BIT_PER_EN])
        else $error("wake did not restore peripherals");
    // Read port: data only in the cycle after a read strobe
    chk_read_idle_zero: assert property (@(posedge clock) disable iff (reset)
        (clock_enable && !read_strobe) |=> read_data == 16'h0000)
        else $error("read data without read strobe");
    chk_read_gating: assert property (@(posedge clock) disable iff (reset)
        (clock_enable && read_strobe && address == ADDR_PER_GATE) |=> read_data == $past(peripheral_clock_gating))
        else $error("gating read back wrong");
    chk_key_reads_zero: assert property (@(posedge clock) disable iff (reset)
        (clock_enable && read_strobe && address == ADDR_CORE_KEY_BEF) |=> read_data == 16'h0000)
        else $error("key register read not zero");
    cov_gate_write: cover property (@(posedge clock) disable iff (reset) commit_per);
    cov_clk_write: cover property (@(posedge clock) disable iff (reset) commit_clk);
    cov_wake_done: cover property (@(posedge clock) disable iff (reset) wake_done);
    cov_core_write: cover property (@(posedge clock) disable iff (reset) commit_core);
    cov_freeze_write: cover property (@(posedge clock) disable iff (reset) !clock_enable && write_strobe);
endmodule // pckc_top
`default_nettype wire
